// *** ept_defines.svh ***
// constants for the encoder position teach block: offsets, fields, resets
// assumes inclusion by bare name from the store model, the top module and the bench
`ifndef EPT_DEFINES_SVH
`define EPT_DEFINES_SVH

// ============================================================
// register byte offsets
`define EPT_CTRL_OFS      8'h00
`define EPT_ORIGIN_OFS    8'h04
`define EPT_PERIOD_OFS    8'h08
`define EPT_RANGE_OFS     8'h0C
`define EPT_REF_OFS       8'h10
`define EPT_OFFSET_OFS    8'h14
`define EPT_STATUS_OFS    8'h18
`define EPT_ISTAT_OFS     8'h1C
`define EPT_IMASK_OFS     8'h20
`define EPT_POS_OFS       8'h24
`define EPT_RAW_OFS       8'h28
// ============================================================
// control fields
`define EPT_CTRL_ABS_BIT    0
`define EPT_CTRL_PER_BIT    1
`define EPT_CTRL_TEACH_BIT  2
// status fields
`define EPT_ST_REL_BIT      0
`define EPT_ST_ABS_BIT      1
`define EPT_ST_TAUGHT_BIT   2
`define EPT_ST_BUSY_BIT     3
// interrupt fields
`define EPT_IRQ_DONE_BIT    0
`define EPT_IRQ_FAIL_BIT    1
`define EPT_IRQ_OVF_BIT     2
// ============================================================
// reset values
`define EPT_CTRL_RST    32'h0000_0000
`define EPT_RANGE_RST   32'h0000_4000
`define EPT_PERIOD_RST  32'h0000_0000
// ============================================================
// timing: revalidation after a teach, longest time 1.5 s
`define EPT_REVALID_MS      1500
`define EPT_CLK_MHZ         100
`define EPT_REVALID_CYC     (`EPT_REVALID_MS * 1000 * `EPT_CLK_MHZ)
// nonvolatile store write time, a plain default
`define EPT_NV_WR_CYC       16

`endif

// *** ept_pkg.sv ***
// types for the encoder position teach block
// assumes ept_defines.svh sits in the same folder
package ept_pkg;
    typedef enum logic [1:0] {
        EPT_IDLE,
        EPT_STORE,
        EPT_WAIT
    } ept_teach_state_t;
endpackage : ept_pkg

// *** ept_nv_store.sv ***
// nonvolatile offset store model with a fixed write time
// assumes one write request at a time; contents survive aresetn
`timescale 1ns/1ns
`default_nettype none
`include "ept_defines.svh"
module ept_nv_store (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write request
    input  wire logic        wr_req,
    input  wire logic [31:0] wr_data,
    // state
    output logic             wr_done,
    output logic [31:0]      rd_data,
    output logic             rd_valid
);
    logic [31:0] mem_reg;
    logic [31:0] mem_next;
    logic        vld_reg = 1'b0; // empty at power-up, kept over resets
    logic        vld_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic        done_reg;
    logic        done_next;

    // ============================================================
    // write timer; the stored word is never reset
    always_comb begin
        mem_next  = mem_reg;
        vld_next  = vld_reg;
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (wr_req && cnt_reg == 5'h0_0) begin
            cnt_next = 5'(`EPT_NV_WR_CYC);
            mem_next = wr_data;
        end else if (cnt_reg != 5'h0_0) begin
            cnt_next = cnt_reg - 5'h0_1;
            if (cnt_reg == 5'h0_1) begin
                vld_next  = 1'b1;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        mem_reg <= mem_next;
        vld_reg <= vld_next;
        if (!aresetn) begin
            cnt_reg  <= 5'h0_0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign wr_done  = done_reg;
    assign rd_data  = mem_reg;
    assign rd_valid = vld_reg;
endmodule : ept_nv_store
`default_nettype wire

// *** ept_top.sv ***
// encoder position teach: origin, periodic wrap, overflow filter, teach
// assumes one encoder sample strobe per logic cycle, AXI4-Lite registers
// Operation
// - at periodic length the count restarts from the origin value
// - origin value shifts the absolute position, allowing negative range
// - teach rising edge computes offset to reference, writes it nonvolatile
// - teach succeeds only while relative position is valid
// - stored offset is always added, also after every restart
// - teach edge drops absolute validity; success restores within 1.5 s
// - jumps of half range or more are overflows; such samples are ignored, here only in absolute mode with relative position valid
// - configurable increment range is the wrap range for overflow
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ept_defines.svh"
module ept_top
    import ept_pkg::*;
#(
    parameter int unsigned REVALID_CYC = `EPT_REVALID_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // encoder sample
    input  wire logic [31:0] enc_pos,
    input  wire logic        enc_strobe,
    input  wire logic        enc_ok,
    input  wire logic        teach_in,
    // motion output
    output logic [31:0]      motion_pos,
    output logic             motion_rel_valid,
    output logic             motion_abs_valid,
    output logic             irq
);
    // ============================================================
    // registers
    logic [31:0] ctrl_reg, ctrl_next, origin_reg, origin_next;
    logic [31:0] period_reg, period_next, range_reg, range_next;
    logic [31:0] ref_reg, ref_next, istat_reg, istat_next;
    logic [31:0] imask_reg, imask_next;
    logic [31:0] raw_reg, raw_next, last_reg, last_next;
    logic [31:0] pos_reg, pos_next, offset_reg, offset_next;
    logic        rel_reg, rel_next, abs_reg, abs_next;
    logic        teach_d_reg, sw_teach_reg, sw_teach_next;
    logic        irq_reg, irq_next;
    ept_teach_state_t st_reg, st_next;
    logic [31:0] tmr_reg, tmr_next;
    // bus registers
    logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic        arr_reg, arr_next, rv_reg, rv_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    // nv store
    logic        nv_req, nv_done, nv_vld;
    logic [31:0] nv_data;

    ept_nv_store u_nv (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_req   (nv_req),
        .wr_data  (offset_reg),
        .wr_done  (nv_done),
        .rd_data  (nv_data),
        .rd_valid (nv_vld)
    );

    // decode shared by read and write paths
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a[1:0] == 2'h0) && (a <= `EPT_RAW_OFS);
    endfunction : known_addr

    // ============================================================
    // position path
    logic [31:0] diff, half, wrapped, shifted, span;
    logic        jump, teach_edge, start_teach;
    always_comb begin
        diff    = enc_pos - last_reg;
        half    = {1'b0, range_reg[31:1]};
        // distance modulo 2^32, either direction
        if (diff[31]) diff = 32'h0000_0000 - diff;
        jump    = ctrl_reg[`EPT_CTRL_ABS_BIT] && (diff >= half);
        // raw plus stored offset
        shifted = enc_pos + offset_reg;
        span    = period_reg;
        wrapped = shifted;
        if (ctrl_reg[`EPT_CTRL_PER_BIT] && span != 32'h0000_0000) begin
            wrapped = shifted % span;
        end
        wrapped = wrapped + origin_reg;
    end

    // teach edge from pin or software pulse
    assign teach_edge  = (teach_in && !teach_d_reg) || sw_teach_reg;
    assign start_teach = teach_edge && st_reg == EPT_IDLE;
    assign nv_req      = st_reg == EPT_STORE;

    // ============================================================
    // datapath and teach sequencing
    always_comb begin
        raw_next    = raw_reg;
        last_next   = last_reg;
        pos_next    = pos_reg;
        rel_next    = rel_reg;
        abs_next    = abs_reg;
        offset_next = offset_reg;
        st_next     = st_reg;
        tmr_next    = tmr_reg;
        istat_next  = 32'h0000_0000;
        if (enc_strobe) begin
            if (!enc_ok) begin
                rel_next = 1'b0;
            end else if (jump && rel_reg) begin
                istat_next[`EPT_IRQ_OVF_BIT] = 1'b1;
            end else begin
                raw_next  = enc_pos;
                last_next = enc_pos;
                pos_next  = wrapped;
                rel_next  = 1'b1;
                abs_next  = abs_reg || (st_reg == EPT_IDLE && nv_vld
                            && ctrl_reg[`EPT_CTRL_ABS_BIT]);
            end
        end
        case (st_reg)
            EPT_IDLE: begin
                if (start_teach) begin
                    abs_next = 1'b0;
                    if (rel_reg) begin
                        offset_next = ref_reg - raw_reg;
                        st_next     = EPT_STORE;
                        tmr_next    = 32'(REVALID_CYC);
                    end else begin
                        istat_next[`EPT_IRQ_FAIL_BIT] = 1'b1;
                    end
                end
            end
            EPT_STORE: st_next = EPT_WAIT;
            EPT_WAIT: begin
                tmr_next = tmr_reg - 32'h0000_0001;
                if (nv_done) begin
                    abs_next = 1'b1;
                    st_next  = EPT_IDLE;
                    istat_next[`EPT_IRQ_DONE_BIT] = 1'b1;
                end else if (tmr_reg == 32'h0000_0001) begin
                    st_next  = EPT_IDLE;
                    istat_next[`EPT_IRQ_FAIL_BIT] = 1'b1;
                end
            end
            default: st_next = EPT_IDLE;
        endcase
        // reload stored offset after restart
        if (st_reg == EPT_IDLE && !start_teach && nv_vld) begin
            offset_next = nv_data;
        end
    end

    // ============================================================
    // axi4-lite slave: one write and one read in flight
    logic do_wr, do_rd;
    assign do_wr = awr_reg && wr_reg && !bv_reg;
    assign do_rd = arr_reg && !rv_reg;
    always_comb begin
        awr_next = awr_reg; wr_next = wr_reg; bv_next = bv_reg;
        arr_next = arr_reg; rv_next = rv_reg;
        bresp_next = bresp_reg; rresp_next = rresp_reg; rdata_next = rdata_reg;
        ctrl_next = ctrl_reg; origin_next = origin_reg;
        period_next = period_reg; range_next = range_reg;
        ref_next = ref_reg; imask_next = imask_reg; sw_teach_next = 1'b0;
        // readies rise together once both valids stand
        if (s_axi_awvalid && s_axi_wvalid && !awr_reg && !bv_reg) begin
            awr_next = 1'b1;
            wr_next  = 1'b1;
        end
        if (awr_reg) awr_next = 1'b0;
        if (wr_reg) wr_next = 1'b0;
        if (bv_reg && s_axi_bready) bv_next = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && awr_reg && wr_reg) begin
            bv_next    = 1'b1;
            bresp_next = known_addr(s_axi_awaddr) ? 2'b00 : 2'b10;
            case (s_axi_awaddr)
                `EPT_CTRL_OFS: begin
                    ctrl_next     = s_axi_wdata & 32'h0000_0003;
                    sw_teach_next = s_axi_wdata[`EPT_CTRL_TEACH_BIT];
                end
                `EPT_ORIGIN_OFS: origin_next = s_axi_wdata;
                `EPT_PERIOD_OFS: period_next = s_axi_wdata;
                `EPT_RANGE_OFS:  range_next  = s_axi_wdata;
                `EPT_REF_OFS:    ref_next    = s_axi_wdata;
                `EPT_IMASK_OFS:  imask_next  = s_axi_wdata & 32'h0000_0007;
                default: ;
            endcase
        end
        // read
        if (s_axi_arvalid && !arr_reg && !rv_reg) arr_next = 1'b1;
        if (arr_reg) arr_next = 1'b0;
        if (rv_reg && s_axi_rready) rv_next = 1'b0;
        if (s_axi_arvalid && arr_reg && !rv_reg) begin
            rv_next    = 1'b1;
            rresp_next = known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                `EPT_CTRL_OFS:   rdata_next = ctrl_reg;
                `EPT_ORIGIN_OFS: rdata_next = origin_reg;
                `EPT_PERIOD_OFS: rdata_next = period_reg;
                `EPT_RANGE_OFS:  rdata_next = range_reg;
                `EPT_REF_OFS:    rdata_next = ref_reg;
                `EPT_OFFSET_OFS: rdata_next = offset_reg;
                `EPT_STATUS_OFS: rdata_next = {28'h000_0000,
                    st_reg != EPT_IDLE, nv_vld, abs_reg, rel_reg};
                `EPT_ISTAT_OFS:  rdata_next = istat_reg;
                `EPT_IMASK_OFS:  rdata_next = imask_reg;
                `EPT_POS_OFS:    rdata_next = pos_reg;
                `EPT_RAW_OFS:    rdata_next = raw_reg;
                default:         rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // write-one-to-clear; a same-cycle hardware set wins
    logic [31:0] istat_final;
    always_comb begin
        istat_final = istat_reg;
        if (s_axi_awvalid && s_axi_wvalid && awr_reg && wr_reg
            && s_axi_awaddr == `EPT_ISTAT_OFS) begin
            istat_final = istat_reg & ~s_axi_wdata;
        end
        istat_final = istat_final | istat_next;
        irq_next    = |(istat_final & imask_next);
    end

    // ============================================================
    // registering
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `EPT_CTRL_RST; origin_reg <= 32'h0000_0000;
            period_reg <= `EPT_PERIOD_RST; range_reg <= `EPT_RANGE_RST;
            ref_reg <= 32'h0000_0000; imask_reg <= 32'h0000_0000;
            istat_reg <= 32'h0000_0000; irq_reg <= 1'b0;
            raw_reg <= 32'h0000_0000; last_reg <= 32'h0000_0000;
            pos_reg <= 32'h0000_0000; offset_reg <= 32'h0000_0000;
            rel_reg <= 1'b0; abs_reg <= 1'b0; teach_d_reg <= 1'b0;
            sw_teach_reg <= 1'b0; st_reg <= EPT_IDLE; tmr_reg <= 32'h0000_0000;
            awr_reg <= 1'b0; wr_reg <= 1'b0; bv_reg <= 1'b0;
            arr_reg <= 1'b0; rv_reg <= 1'b0; bresp_reg <= 2'b00;
            rresp_reg <= 2'b00; rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next; origin_reg <= origin_next;
            period_reg <= period_next; range_reg <= range_next;
            ref_reg <= ref_next; imask_reg <= imask_next;
            istat_reg <= istat_final; irq_reg <= irq_next;
            raw_reg <= raw_next; last_reg <= last_next;
            pos_reg <= pos_next; offset_reg <= offset_next;
            rel_reg <= rel_next; abs_reg <= abs_next;
            teach_d_reg <= teach_in; sw_teach_reg <= sw_teach_next;
            st_reg <= st_next; tmr_reg <= tmr_next;
            awr_reg <= awr_next; wr_reg <= wr_next; bv_reg <= bv_next;
            arr_reg <= arr_next; rv_reg <= rv_next; bresp_reg <= bresp_next;
            rresp_reg <= rresp_next; rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready    = awr_reg;
    assign s_axi_wready     = wr_reg;
    assign s_axi_bvalid     = bv_reg;
    assign s_axi_bresp      = bresp_reg;
    assign s_axi_arready    = arr_reg;
    assign s_axi_rvalid     = rv_reg;
    assign s_axi_rresp      = rresp_reg;
    assign s_axi_rdata      = rdata_reg;
    assign motion_pos       = pos_reg;
    assign motion_rel_valid = rel_reg;
    assign motion_abs_valid = abs_reg;
    assign irq              = irq_reg;
endmodule : ept_top
`default_nettype wire

// *** ept_enc_model.sv ***
// encoder model: one position sample every gap+1 cycles
// assumes the bench sets gap, position and frame status
`timescale 1ns/1ns
`default_nettype none
module ept_enc_model (
    // clock
    input  wire logic        aclk,
    // what the next frame carries
    input  wire logic [7:0]  gap,
    input  wire logic [31:0] pos_set,
    input  wire logic        ok_set,
    // sample lines
    output logic [31:0]      enc_pos,
    output logic             enc_strobe,
    output logic             enc_ok
);
    logic [7:0] cnt = 8'h00;
    // between frames the lines toggle each cycle, so the last value shows every second cycle
    always_ff @(posedge aclk) begin
        if (cnt >= gap) begin
            cnt <= 8'h00;
            enc_strobe <= 1'b1;
            enc_pos <= pos_set;
            enc_ok <= ok_set;
        end else begin
            cnt <= cnt + 8'h01;
            enc_strobe <= 1'b0;
            enc_pos <= ~enc_pos;
            enc_ok <= ~enc_ok;
        end
    end
endmodule : ept_enc_model
`default_nettype wire

// *** ept_top_asserts.sv ***
// checker for ept_top: teach, validity and bus handshake timing
// assumes it is bound to ept_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module ept_top_chk #(
    parameter int unsigned REVALID_CYC = 100
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // encoder and motion side
    input wire logic enc_strobe,
    input wire logic enc_ok,
    input wire logic teach_in,
    input wire logic motion_rel_valid,
    input wire logic motion_abs_valid,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // helper: how long a good teach keeps the position invalid
    logic        tq_reg, arm_reg, arm_next;
    int unsigned wt_reg, wt_next;
    always_comb begin
        arm_next = arm_reg;
        wt_next = arm_reg ? wt_reg + 1 : 0;
        if (teach_in && !tq_reg && motion_rel_valid) begin
            arm_next = 1'b1;
            wt_next = 0;
        end else if (motion_abs_valid && wt_reg > 4) begin
            arm_next = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        tq_reg <= aresetn & teach_in;
        arm_reg <= aresetn & arm_next;
        wt_reg <= aresetn ? wt_next : 0;
    end
    // ==========================================================
    sequence teach_edge;
        $rose(teach_in);
    endsequence
    sequence abs_gone;
        ##[1:3] !motion_abs_valid;
    endsequence
    a_teach_drops_abs: assert property (teach_edge |-> abs_gone)
        else $error("absolute valid kept after teach edge");
    a_revalid_bound: assert property (wt_reg <= REVALID_CYC + 40)
        else $error("absolute valid not restored in time");
    a_fail_no_abs: assert property (teach_edge and !motion_rel_valid
        |-> ##1 !motion_abs_valid [*4])
        else $error("absolute valid after refused teach");
    a_good_sets_rel: assert property (enc_strobe && enc_ok
        |-> ##[1:2] motion_rel_valid)
        else $error("good sample left relative invalid");
    a_bad_drops_rel: assert property (enc_strobe && !enc_ok
        |-> ##[1:2] !motion_rel_valid)
        else $error("bad sample left relative valid");
    a_bresp_follows: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_rresp_follows: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> $stable(s_axi_rvalid))
        else $error("read data dropped early");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq
        && !motion_abs_valid && !motion_rel_valid && !s_axi_bvalid)
        else $error("outputs active right after reset");
endmodule : ept_top_chk
bind ept_top ept_top_chk #(.REVALID_CYC(REVALID_CYC)) chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .enc_strobe(enc_strobe),
    .enc_ok(enc_ok), .teach_in(teach_in),
    .motion_rel_valid(motion_rel_valid),
    .motion_abs_valid(motion_abs_valid), .irq(irq));
`default_nettype wire

// *** ept_top_tb_top.sv ***
// bench for ept_top: register calls, encoder samples and teach pulses
// assumes ept_defines.svh, ept_pkg, ept_enc_model and the checker
`timescale 1ns/1ns
`default_nettype none
`include "ept_defines.svh"
module ept_top_tb_top;
    localparam int unsigned REV = 100;
    logic aclk, aresetn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara, gap;
    logic [31:0] wd, rdat, pos, pset, mpos;
    logic [1:0] bresp, rresp;
    logic strb, ok, oset, teach, relv, absv, irq;
    int fail_count = 0;
    int tests_run = 0;
    ept_top #(.REVALID_CYC(REV)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .enc_pos(pos),
        .enc_strobe(strb), .enc_ok(ok), .teach_in(teach),
        .motion_pos(mpos), .motion_rel_valid(relv),
        .motion_abs_valid(absv), .irq(irq));
    ept_enc_model enc (.aclk(aclk), .gap(gap), .pos_set(pset),
        .ok_set(oset), .enc_pos(pos), .enc_strobe(strb), .enc_ok(ok));
    // ==========================================================
    // clock and watchdog
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #500_000;
        fail_count++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check
    // ==========================================================
    // bus calls: valids held until each channel's own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        logic [2:0] got;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        got = 3'b000;
        while (!got[2] && n < 64) begin
            @(posedge aclk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_r === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) begin
                got = {1'b1, bresp};
                br <= 1'b0;
            end
        end
        check(got, {1'b1, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        int n;
        logic [34:0] got;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        got = '0;
        while (!got[34] && n < 64) begin
            @(posedge aclk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) begin
                got = {1'b1, rresp, rdat};
                rr <= 1'b0;
            end
        end
        check(got[34:32], {1'b1, er});
        check(got[31:0], exp);
    endtask : rd
    // second strobe after the change surely carries the new sample
    task automatic feed(input logic [31:0] p, input logic o);
        pset <= p;
        oset <= o;
        repeat (2) begin
            @(posedge aclk);
            while (strb !== 1'b1) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask : feed
    task automatic teach_pulse(input logic good);
        int n;
        @(posedge aclk);
        teach <= 1'b1;
        repeat (3) @(posedge aclk);
        check(absv, 1'b0);
        teach <= 1'b0;
        n = 0;
        while (good && absv !== 1'b1 && n < REV + 40) begin
            @(posedge aclk);
            n++;
        end
        check(absv, good);
    endtask : teach_pulse
    // ==========================================================
    initial begin
        {aresetn, awv, wv, br, arv, rr, oset, teach} = '0;
        {awa, ara, wd, pset} = '0;
        gap = 8'h03;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({irq, relv, absv, mpos}, '0);
        rd(`EPT_CTRL_OFS, `EPT_CTRL_RST, 2'b00);
        rd(`EPT_RANGE_OFS, `EPT_RANGE_RST, 2'b00);
        rd(`EPT_PERIOD_OFS, `EPT_PERIOD_RST, 2'b00);
        rd(8'h2C, 32'h0000_0000, 2'b10);
        wr(8'h2C, 32'h0000_0001, 2'b10);
        wr(`EPT_IMASK_OFS, 32'h0000_0007, 2'b00);
        // teach refused while frames are bad
        teach_pulse(1'b0);
        rd(`EPT_ISTAT_OFS, 32'h0000_0002, 2'b00);
        check(irq, 1'b1);
        wr(`EPT_ISTAT_OFS, 32'h0000_0002, 2'b00);
        check(irq, 1'b0);
        // good teach: reference 5000 at raw 1000
        feed(32'h0000_03E8, 1'b1);
        check({relv, absv, mpos}, {2'b10, 32'h0000_03E8});
        wr(`EPT_REF_OFS, 32'h0000_1388, 2'b00);
        teach_pulse(1'b1);
        rd(`EPT_OFFSET_OFS, 32'h0000_0FA0, 2'b00);
        rd(`EPT_ISTAT_OFS, 32'h0000_0001, 2'b00);
        wr(`EPT_ISTAT_OFS, 32'h0000_0001, 2'b00);
        feed(32'h0000_03E8, 1'b1);
        check(mpos, 32'h0000_1388);
        // origin -100, then period 1024 wrapping back to origin
        wr(`EPT_ORIGIN_OFS, 32'hFFFF_FF9C, 2'b00);
        feed(32'h0000_03E8, 1'b1);
        check(mpos, 32'h0000_1324);
        wr(`EPT_PERIOD_OFS, 32'h0000_0400, 2'b00);
        wr(`EPT_CTRL_OFS, 32'h0000_0002, 2'b00);
        feed(32'h0000_0460, 1'b1);
        check(mpos, 32'hFFFF_FF9C);
        feed(32'h0000_045F, 1'b1);
        check(mpos, 32'h0000_039B);
        // restart in mid-run with slow frames: offset still applied
        gap <= 8'h0F;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wr(`EPT_ORIGIN_OFS, 32'h0000_0000, 2'b00);
        wr(`EPT_IMASK_OFS, 32'h0000_0007, 2'b00);
        feed(32'h0000_03E8, 1'b1);
        check(mpos, 32'h0000_1388);
        rd(`EPT_STATUS_OFS, 32'h0000_0005, 2'b00);
        // absolute mode, range 4000: a jump of exactly half is ignored
        wr(`EPT_RANGE_OFS, 32'h0000_0FA0, 2'b00);
        wr(`EPT_CTRL_OFS, 32'h0000_0001, 2'b00);
        feed(32'h0000_03E8, 1'b1);
        check({absv, mpos}, {1'b1, 32'h0000_1388});
        feed(32'h0000_0BB8, 1'b1);
        check({irq, mpos}, {1'b1, 32'h0000_1388});
        wr(`EPT_IMASK_OFS, 32'h0000_0003, 2'b00);
        check(irq, 1'b0);
        feed(32'h0000_0BB7, 1'b1);
        check(mpos, 32'h0000_1B57);
        wr(`EPT_ISTAT_OFS, 32'h0000_0004, 2'b00);
        rd(`EPT_ISTAT_OFS, 32'h0000_0000, 2'b00);
        // configuration changed: teach again to reference 0
        wr(`EPT_REF_OFS, 32'h0000_0000, 2'b00);
        teach_pulse(1'b1);
        rd(`EPT_OFFSET_OFS, 32'hFFFF_F449, 2'b00);
        feed(32'h0000_0BB7, 1'b1);
        check(mpos, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : ept_top_tb_top
`default_nettype wire
